//--- core/core_subset_cfg.svh
// Constants of the instruction subset core: status bit positions,
// pointer register indices and reset values.
// Assumes inclusion by bare name from the core design files.
`ifndef CORE_SUBSET_CFG_SVH
`define CORE_SUBSET_CFG_SVH

// Status register bit positions
`define SR_C 3'd0
`define SR_Z 3'd1
`define SR_N 3'd2
`define SR_V 3'd3
`define SR_S 3'd4
`define SR_H 3'd5
`define SR_T 3'd6
`define SR_I 3'd7

// Pointer pairs, index of the low byte
`define PTR_X 5'd26
`define PTR_Y 5'd28
`define PTR_Z 5'd30

// Reset values
`define SP_RESET 16'h00ff
`define PC_RESET 16'h0000
`define SR_RESET 8'h00

`endif

//--- core/core_subset_pkg.sv
// Types shared by the instruction subset core and its helpers.
// Assumes nothing of its surroundings.
package core_subset_pkg;
   typedef enum logic [2:0] {ST_RUN, ST_DATA, ST_PROG1, ST_PROG2, ST_IOBIT, ST_SLOT} state_t;
   typedef enum logic [1:0] {PM_NONE, PM_INC, PM_DEC, PM_DISP} ptr_mode_t;
   typedef enum logic [2:0] {SH_LSL, SH_ROL, SH_LSR, SH_ROR, SH_ASR, SH_SWAP} shift_op_t;
   typedef enum logic [4:0] {
      OP_NOP, OP_BRANCH, OP_IOBIT, OP_SHIFT, OP_FLAG, OP_BST, OP_BLD, OP_MOV, OP_PAIR_COPY,
      OP_LDI, OP_LOAD, OP_STORE, OP_LDS, OP_STS, OP_LPM, OP_PUSH, OP_POP, OP_IN, OP_OUT
   } op_t;
endpackage

//--- core/shift_unit.sv
// Shift, rotate and nibble swap datapath with its flag results.
// Assumes a purely combinational use inside the core.
`timescale 1ns/1ns
`default_nettype none
module shift_unit (
   input  wire logic                        cin,
   input  wire core_subset_pkg::shift_op_t  op,
   input  wire logic [7:0]                  din,
   output logic      [7:0]                  dout,
   output logic                             c_out,
   output logic                             z_out,
   output logic                             n_out,
   output logic                             v_out
);
   // Result and bit shifted out
   always_comb begin
      dout  = din;
      c_out = cin;
      case (op)
         core_subset_pkg::SH_LSL: begin
            dout  = {din[6:0], 1'b0};
            c_out = din[7];
         end
         core_subset_pkg::SH_ROL: begin
            dout  = {din[6:0], cin};
            c_out = din[7];
         end
         core_subset_pkg::SH_LSR: begin
            dout  = {1'b0, din[7:1]};
            c_out = din[0];
         end
         core_subset_pkg::SH_ROR: begin
            dout  = {cin, din[7:1]};
            c_out = din[0];
         end
         core_subset_pkg::SH_ASR: begin
            dout  = {din[7], din[7:1]};
            c_out = din[0];
         end
         core_subset_pkg::SH_SWAP: dout = {din[3:0], din[7:4]};
         default: dout = din;
      endcase
   end

   // Flags from the result
   assign z_out = (dout == 8'h00);
   assign n_out = dout[7];
   assign v_out = dout[7] ^ c_out;
endmodule
`default_nettype wire

//--- core/ptr_unit.sv
// Effective address and updated pointer for indirect accesses.
// Assumes a purely combinational use inside the core.
`timescale 1ns/1ns
`default_nettype none
module ptr_unit (
   input  wire logic [15:0]                 ptr,
   input  wire core_subset_pkg::ptr_mode_t  mode,
   input  wire logic [5:0]                  disp,
   output logic      [15:0]                 addr,
   output logic      [15:0]                 ptr_next
);
   // Post-increment uses the old value, pre-decrement the new one
   always_comb begin
      addr     = ptr;
      ptr_next = ptr;
      case (mode)
         core_subset_pkg::PM_INC: ptr_next = ptr + 16'h0001;
         core_subset_pkg::PM_DEC: begin
            ptr_next = ptr - 16'h0001;
            addr     = ptr - 16'h0001;
         end
         core_subset_pkg::PM_DISP: addr = ptr + {10'h000, disp};
         default: addr = ptr;
      endcase
   end
endmodule
`default_nettype wire

//--- core/core_subset.sv
// Executes the bit, shift, move, load/store and branch subset of the core.
// Assumes data and I/O memories answer in the cycle a request flop is high,
// program memory on the cycle after, and that insn_ext holds the word after insn_word.
`timescale 1ns/1ns
`default_nettype none
`include "core_subset_cfg.svh"
module core_subset #(
   parameter logic [15:0] SP_INIT = `SP_RESET
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        insn_valid,
   input  wire logic [15:0] insn_word,
   input  wire logic [15:0] insn_ext,
   output logic             insn_ready_q,
   output logic      [15:0] pc_q,
   output logic      [7:0]  status_register_q,
   output logic      [15:0] dmem_addr_q,
   output logic      [7:0]  dmem_wdata_q,
   output logic             dmem_we_q,
   output logic             dmem_re_q,
   input  wire logic [7:0]  dmem_rdata,
   output logic      [15:0] pmem_addr_q,
   output logic             pmem_re_q,
   input  wire logic [7:0]  pmem_rdata,
   output logic      [5:0]  io_addr_q,
   output logic      [7:0]  io_wdata_q,
   output logic             io_we_q,
   output logic             io_re_q,
   input  wire logic [7:0]  io_rdata
);
   core_subset_pkg::state_t    st_q, st_d;
   core_subset_pkg::op_t       op;
   core_subset_pkg::ptr_mode_t p_mode;
   core_subset_pkg::shift_op_t sh_op;
   logic [7:0]  rf_q [32];
   logic [7:0]  rf_d [32];
   logic [15:0] pc_d, sp_q, sp_d, dmem_addr_d, pmem_addr_d;
   logic [7:0]  sr_d, dmem_wdata_d, io_wdata_d, io_mod;
   logic [5:0]  io_addr_d;
   logic [4:0]  dst_q, dst_d, p_idx, fd, fr;
   logic [2:0]  bit_q, bit_d;
   logic        ready_d, dmem_we_d, dmem_re_d, pmem_re_d, io_we_d, io_re_d;
   logic        io_wb_q, io_wb_d, set_q, set_d, p_ok, take, br_hit;
   logic [15:0] p_val, p_addr, p_next, k_ext;
   logic [7:0]  sh_res, rd_fd;
   logic        sh_c, sh_z, sh_n, sh_v;

   // Register read with bypass of a pending port read
   function automatic logic [7:0] rd(input logic [4:0] idx);
      rd = (io_wb_q && idx == dst_q) ? io_rdata : rf_q[idx];
   endfunction

   // Operand fields
   assign fd     = insn_word[8:4];
   assign fr     = {insn_word[9], insn_word[3:0]};
   assign k_ext  = {{9{insn_word[9]}}, insn_word[9:3]};
   assign take   = (st_q == core_subset_pkg::ST_RUN) && insn_valid;
   assign br_hit = (status_register_q[insn_word[2:0]] == !insn_word[10]);

   // Operand reads in a process, so register updates retrigger them
   always_comb begin
      rd_fd = rd(fd);
      p_val = {rd(p_idx | 5'd1), rd(p_idx)};
   end

   // Pointer selection and update mode
   always_comb begin
      p_idx  = `PTR_Z;
      p_mode = core_subset_pkg::PM_NONE;
      p_ok   = 1'b1;
      if (insn_word[15:14] == 2'b10 && !insn_word[12]) begin
         p_idx  = insn_word[3] ? `PTR_Y : `PTR_Z;
         p_mode = core_subset_pkg::PM_DISP;
      end else begin
         case (insn_word[3:0])
            4'h1: p_mode = core_subset_pkg::PM_INC;
            4'h2: p_mode = core_subset_pkg::PM_DEC;
            4'h5: p_mode = core_subset_pkg::PM_INC;
            4'h9: begin
               p_idx  = `PTR_Y;
               p_mode = core_subset_pkg::PM_INC;
            end
            4'ha: begin
               p_idx  = `PTR_Y;
               p_mode = core_subset_pkg::PM_DEC;
            end
            4'hc: p_idx = `PTR_X;
            4'hd: begin
               p_idx  = `PTR_X;
               p_mode = core_subset_pkg::PM_INC;
            end
            4'he: begin
               p_idx  = `PTR_X;
               p_mode = core_subset_pkg::PM_DEC;
            end
            default: p_ok = 1'b0;
         endcase
      end
   end

   // Instruction class and shift kind
   always_comb begin
      op    = core_subset_pkg::OP_NOP;
      sh_op = core_subset_pkg::SH_SWAP;
      casez (insn_word)
         16'b1111_0???_????_????: op = core_subset_pkg::OP_BRANCH;
         16'b1001_10?0_????_????: op = core_subset_pkg::OP_IOBIT;
         16'b000?_11??_????_????: begin
            sh_op = insn_word[12] ? core_subset_pkg::SH_ROL : core_subset_pkg::SH_LSL;
            if (fd == fr) op = core_subset_pkg::OP_SHIFT;
         end
         16'b1001_010?_????_0010: op = core_subset_pkg::OP_SHIFT;
         16'b1001_010?_????_0101: begin
            op    = core_subset_pkg::OP_SHIFT;
            sh_op = core_subset_pkg::SH_ASR;
         end
         16'b1001_010?_????_011?: begin
            op    = core_subset_pkg::OP_SHIFT;
            sh_op = insn_word[0] ? core_subset_pkg::SH_ROR : core_subset_pkg::SH_LSR;
         end
         16'b1001_0100_????_1000: op = core_subset_pkg::OP_FLAG;
         16'b1001_0101_1100_1000: op = core_subset_pkg::OP_LPM;
         16'b1111_101?_????_0???: op = core_subset_pkg::OP_BST;
         16'b1111_100?_????_0???: op = core_subset_pkg::OP_BLD;
         16'b0010_11??_????_????: op = core_subset_pkg::OP_MOV;
         16'b0000_0001_????_????: op = core_subset_pkg::OP_PAIR_COPY;
         16'b1110_????_????_????: op = core_subset_pkg::OP_LDI;
         16'b10?0_??0?_????_????: op = core_subset_pkg::OP_LOAD;
         16'b10?0_??1?_????_????: op = core_subset_pkg::OP_STORE;
         16'b1001_000?_????_0000: op = core_subset_pkg::OP_LDS;
         16'b1001_001?_????_0000: op = core_subset_pkg::OP_STS;
         16'b1001_000?_????_010?: op = core_subset_pkg::OP_LPM;
         16'b1001_000?_????_1111: op = core_subset_pkg::OP_POP;
         16'b1001_001?_????_1111: op = core_subset_pkg::OP_PUSH;
         16'b1001_000?_????_????: if (p_ok) op = core_subset_pkg::OP_LOAD;
         16'b1001_001?_????_????: if (p_ok) op = core_subset_pkg::OP_STORE;
         16'b1011_0???_????_????: op = core_subset_pkg::OP_IN;
         16'b1011_1???_????_????: op = core_subset_pkg::OP_OUT;
         default: op = core_subset_pkg::OP_NOP;
      endcase
   end

   shift_unit u_shift (
      .cin   (status_register_q[`SR_C]),
      .op    (sh_op),
      .din   (rd_fd),
      .dout  (sh_res),
      .c_out (sh_c),
      .z_out (sh_z),
      .n_out (sh_n),
      .v_out (sh_v)
   );

   ptr_unit u_ptr (
      .ptr      (p_val),
      .mode     (p_mode),
      .disp     ({insn_word[13], insn_word[11:10], insn_word[2:0]}),
      .addr     (p_addr),
      .ptr_next (p_next)
   );

   // Next state of the whole core
   always_comb begin
      io_mod          = io_rdata;
      io_mod[bit_q]   = set_q;
      rf_d            = rf_q;
      sr_d            = status_register_q;
      sp_d            = sp_q;
      pc_d            = pc_q;
      st_d            = st_q;
      ready_d         = insn_ready_q;
      dst_d           = dst_q;
      bit_d           = bit_q;
      set_d           = set_q;
      dmem_addr_d     = dmem_addr_q;
      dmem_wdata_d    = dmem_wdata_q;
      pmem_addr_d     = pmem_addr_q;
      io_addr_d       = io_addr_q;
      io_wdata_d      = io_wdata_q;
      dmem_we_d       = 1'b0;
      dmem_re_d       = 1'b0;
      pmem_re_d       = 1'b0;
      io_we_d         = 1'b0;
      io_re_d         = 1'b0;
      io_wb_d         = 1'b0;
      if (io_wb_q) rf_d[dst_q] = io_rdata;
      case (st_q)
         core_subset_pkg::ST_RUN: if (insn_valid) begin
            pc_d = pc_q + 16'h0001;
            case (op)
               core_subset_pkg::OP_BRANCH: if (br_hit) begin
                  pc_d    = pc_q + k_ext + 16'h0001;
                  ready_d = 1'b0;
                  st_d    = core_subset_pkg::ST_SLOT;
               end
               core_subset_pkg::OP_IOBIT: begin
                  io_addr_d = {1'b0, insn_word[7:3]};
                  io_re_d   = 1'b1;
                  bit_d     = insn_word[2:0];
                  set_d     = insn_word[9];
                  ready_d   = 1'b0;
                  st_d      = core_subset_pkg::ST_IOBIT;
               end
               core_subset_pkg::OP_SHIFT: begin
                  rf_d[fd] = sh_res;
                  if (sh_op != core_subset_pkg::SH_SWAP) begin
                     sr_d[`SR_C] = sh_c;
                     sr_d[`SR_Z] = sh_z;
                     sr_d[`SR_N] = sh_n;
                     sr_d[`SR_V] = sh_v;
                  end
               end
               core_subset_pkg::OP_FLAG: sr_d[insn_word[6:4]] = !insn_word[7];
               core_subset_pkg::OP_BST: sr_d[`SR_T] = rd_fd[insn_word[2:0]];
               core_subset_pkg::OP_BLD: rf_d[fd][insn_word[2:0]] = status_register_q[`SR_T];
               core_subset_pkg::OP_MOV: rf_d[fd] = rd(fr);
               core_subset_pkg::OP_PAIR_COPY: begin
                  rf_d[{insn_word[7:4], 1'b0}] = rd({insn_word[3:0], 1'b0});
                  rf_d[{insn_word[7:4], 1'b1}] = rd({insn_word[3:0], 1'b1});
               end
               core_subset_pkg::OP_LDI: rf_d[{1'b1, insn_word[7:4]}] = {insn_word[11:8], insn_word[3:0]};
               core_subset_pkg::OP_LOAD, core_subset_pkg::OP_LDS, core_subset_pkg::OP_POP: begin
                  dmem_re_d   = 1'b1;
                  dst_d       = fd;
                  ready_d     = 1'b0;
                  st_d        = core_subset_pkg::ST_DATA;
                  dmem_addr_d = p_addr;
                  if (op == core_subset_pkg::OP_LDS) begin
                     dmem_addr_d = insn_ext;
                     pc_d        = pc_q + 16'h0002;
                  end
                  if (op == core_subset_pkg::OP_POP) begin
                     dmem_addr_d = sp_q + 16'h0001;
                     sp_d        = sp_q + 16'h0001;
                  end
               end
               core_subset_pkg::OP_STORE, core_subset_pkg::OP_STS, core_subset_pkg::OP_PUSH: begin
                  dmem_we_d    = 1'b1;
                  dmem_wdata_d = rd(fd);
                  ready_d      = 1'b0;
                  st_d         = core_subset_pkg::ST_SLOT;
                  dmem_addr_d  = p_addr;
                  if (op == core_subset_pkg::OP_STS) begin
                     dmem_addr_d = insn_ext;
                     pc_d        = pc_q + 16'h0002;
                  end
                  if (op == core_subset_pkg::OP_PUSH) begin
                     dmem_addr_d = sp_q;
                     sp_d        = sp_q - 16'h0001;
                  end
               end
               core_subset_pkg::OP_LPM: begin
                  pmem_addr_d = p_val;
                  pmem_re_d   = 1'b1;
                  dst_d       = insn_word[10] ? 5'd0 : fd; // Plain form goes to R0
                  ready_d     = 1'b0;
                  st_d        = core_subset_pkg::ST_PROG1;
               end
               core_subset_pkg::OP_IN: begin
                  io_addr_d = {insn_word[10:9], insn_word[3:0]};
                  io_re_d   = 1'b1;
                  io_wb_d   = 1'b1;
                  dst_d     = fd;
               end
               core_subset_pkg::OP_OUT: begin
                  io_addr_d  = {insn_word[10:9], insn_word[3:0]};
                  io_wdata_d = rd(fd);
                  io_we_d    = 1'b1;
               end
               default: pc_d = pc_q + 16'h0001;
            endcase
            // Pointer write-back for the auto-modifying forms
            if ((op == core_subset_pkg::OP_LOAD || op == core_subset_pkg::OP_STORE
                 || op == core_subset_pkg::OP_LPM) && p_mode != core_subset_pkg::PM_DISP) begin
               rf_d[p_idx | 5'd1] = p_next[15:8];
               rf_d[p_idx]        = p_next[7:0];
            end
         end
         core_subset_pkg::ST_DATA: begin
            rf_d[dst_q] = dmem_rdata;
            ready_d     = 1'b1;
            st_d        = core_subset_pkg::ST_RUN;
         end
         core_subset_pkg::ST_PROG1: st_d = core_subset_pkg::ST_PROG2;
         core_subset_pkg::ST_PROG2: begin
            rf_d[dst_q] = pmem_rdata;
            ready_d     = 1'b1;
            st_d        = core_subset_pkg::ST_RUN;
         end
         core_subset_pkg::ST_IOBIT: begin
            io_wdata_d = io_mod;
            io_we_d    = 1'b1;
            ready_d    = 1'b1;
            st_d       = core_subset_pkg::ST_RUN;
         end
         core_subset_pkg::ST_SLOT: begin
            ready_d = 1'b1;
            st_d    = core_subset_pkg::ST_RUN;
         end
         default: begin
            ready_d = 1'b1;
            st_d    = core_subset_pkg::ST_RUN;
         end
      endcase
   end

   // State registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_q              <= '{default: 8'h00};
         st_q              <= core_subset_pkg::ST_RUN;
         status_register_q <= `SR_RESET;
         sp_q              <= SP_INIT;
         pc_q              <= `PC_RESET;
         insn_ready_q      <= 1'b1;
         dst_q             <= 5'h00;
         bit_q             <= 3'h0;
         set_q             <= 1'b0;
         io_wb_q           <= 1'b0;
         dmem_addr_q       <= 16'h0000;
         dmem_wdata_q      <= 8'h00;
         dmem_we_q         <= 1'b0;
         dmem_re_q         <= 1'b0;
         pmem_addr_q       <= 16'h0000;
         pmem_re_q         <= 1'b0;
         io_addr_q         <= 6'h00;
         io_wdata_q        <= 8'h00;
         io_we_q           <= 1'b0;
         io_re_q           <= 1'b0;
      end else begin
         rf_q              <= rf_d;
         st_q              <= st_d;
         status_register_q <= sr_d;
         sp_q              <= sp_d;
         pc_q              <= pc_d;
         insn_ready_q      <= ready_d;
         dst_q             <= dst_d;
         bit_q             <= bit_d;
         set_q             <= set_d;
         io_wb_q           <= io_wb_d;
         dmem_addr_q       <= dmem_addr_d;
         dmem_wdata_q      <= dmem_wdata_d;
         dmem_we_q         <= dmem_we_d;
         dmem_re_q         <= dmem_re_d;
         pmem_addr_q       <= pmem_addr_d;
         pmem_re_q         <= pmem_re_d;
         io_addr_q         <= io_addr_d;
         io_wdata_q        <= io_wdata_d;
         io_we_q           <= io_we_d;
         io_re_q           <= io_re_d;
      end
   end

   // Checks on timing and flag effects
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   br_taken_a: assert property (take && op == core_subset_pkg::OP_BRANCH && br_hit
      |=> !insn_ready_q && pc_q == $past(pc_q) + $past(k_ext) + 16'h0001 ##1 insn_ready_q)
      else $error("taken branch timing or target wrong");
   br_skip_a: assert property (take && op == core_subset_pkg::OP_BRANCH && !br_hit
      |=> insn_ready_q && pc_q == $past(pc_q) + 16'h0001
          && status_register_q == $past(status_register_q))
      else $error("untaken branch wrong");
   io_bit_a: assert property (take && op == core_subset_pkg::OP_IOBIT
      |=> io_re_q && !insn_ready_q ##1 io_we_q && insn_ready_q
          && io_wdata_q[$past(insn_word[2:0], 2)] == $past(insn_word[9], 2))
      else $error("io bit update wrong");
   shift_flag_a: assert property (take && op == core_subset_pkg::OP_SHIFT
      && sh_op != core_subset_pkg::SH_SWAP |=> insn_ready_q
      && status_register_q[`SR_V] == (status_register_q[`SR_N] ^ status_register_q[`SR_C])
      && status_register_q[`SR_N] == rf_q[$past(fd)][7]
      && status_register_q[`SR_Z] == (rf_q[$past(fd)] == 8'h00))
      else $error("shift flags inconsistent");
   swap_keep_a: assert property (take && op == core_subset_pkg::OP_SHIFT
      && sh_op == core_subset_pkg::SH_SWAP |=> $stable(status_register_q))
      else $error("swap changed flags");
   load_two_a: assert property (take && op == core_subset_pkg::OP_LOAD
      |=> dmem_re_q && !insn_ready_q ##1 insn_ready_q)
      else $error("load not two cycles");
   store_two_a: assert property (take && op == core_subset_pkg::OP_STORE
      |=> dmem_we_q && dmem_wdata_q == $past(rd_fd) ##1 insn_ready_q && !dmem_we_q)
      else $error("store not two cycles");
   code_load_a: assert property (take && op == core_subset_pkg::OP_LPM
      |=> pmem_re_q ##1 !insn_ready_q ##1 insn_ready_q)
      else $error("code load not three cycles");
   irq_flag_a: assert property (take && op == core_subset_pkg::OP_FLAG
      && insn_word[6:4] == `SR_I |=> status_register_q[`SR_I] == !$past(insn_word[7]))
      else $error("interrupt flag not updated");

   br_cov: cover property (take && op == core_subset_pkg::OP_BRANCH && br_hit);
   lpm_cov: cover property (take && op == core_subset_pkg::OP_LPM);
   iobit_cov: cover property (take && op == core_subset_pkg::OP_IOBIT);
endmodule
`default_nettype wire

//--- sim/mem_model.sv
// Data, program and I/O memories on the far side of the core.
// Assumes one clock and one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module mem_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] dmem_addr_q,
   input  wire logic [7:0]  dmem_wdata_q,
   input  wire logic        dmem_we_q,
   input  wire logic        dmem_re_q,
   output logic      [7:0]  dmem_rdata,
   input  wire logic [15:0] pmem_addr_q,
   output logic      [7:0]  pmem_rdata,
   input  wire logic [5:0]  io_addr_q,
   input  wire logic [7:0]  io_wdata_q,
   input  wire logic        io_we_q,
   input  wire logic        io_re_q,
   output logic      [7:0]  io_rdata
);
   logic [7:0]  io_mem [64];
   logic [15:0] wr_addr;
   logic [7:0]  wr_data;
   // Data and I/O read data valid only under strobe, inverted otherwise; program read data always valid
   assign dmem_rdata = dmem_re_q ? dmem_addr_q[7:0] ^ 8'h5a : ~(dmem_addr_q[7:0] ^ 8'h5a);
   assign pmem_rdata = pmem_addr_q[7:0] ^ 8'h3c;
   assign io_rdata = io_re_q ? io_mem[io_addr_q] : ~io_mem[io_addr_q];
   // Capture writes
   always @(posedge core_clk) begin
      if (dmem_we_q) begin
         wr_addr <= dmem_addr_q;
         wr_data <= dmem_wdata_q;
      end
      if (io_we_q) io_mem[io_addr_q] <= io_wdata_q;
   end
   initial io_mem[5] = 8'h81;
endmodule
`default_nettype wire

//--- sim/test_mcu_core_insn_subset.sv
// Self-checking bench for the instruction subset core.
// Assumes the memory model beside the core.
`timescale 1ns/1ns
`default_nettype none
module test_mcu_core_insn_subset;
   logic        core_clk, rst_n, insn_valid, rdy, dmem_we_q, dmem_re_q, io_we_q, io_re_q;
   logic [15:0] insn_word, insn_ext, pc_q, dmem_addr_q, pmem_addr_q;
   logic [7:0]  sr, dmem_wdata_q, dmem_rdata, pmem_rdata, io_wdata_q, io_rdata;
   logic [5:0]  io_addr_q;
   int          mismatches, n_checks, cyc, ticks;
   core_subset dut (.core_clk, .rst_n, .insn_valid, .insn_word, .insn_ext,
      .insn_ready_q(rdy), .pc_q, .status_register_q(sr), .dmem_addr_q, .dmem_wdata_q,
      .dmem_we_q, .dmem_re_q, .dmem_rdata, .pmem_addr_q, .pmem_re_q(), .pmem_rdata,
      .io_addr_q, .io_wdata_q, .io_we_q, .io_re_q, .io_rdata);
   mem_model pm (.core_clk, .dmem_addr_q, .dmem_wdata_q, .dmem_we_q, .dmem_re_q,
      .dmem_rdata, .pmem_addr_q, .pmem_rdata, .io_addr_q, .io_wdata_q, .io_we_q,
      .io_re_q, .io_rdata);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Idle one edge, issue one instruction, count cycles until ready
   task automatic exec(input logic [15:0] w, input logic [15:0] k = 16'h0000);
      @(posedge core_clk) #1;
      for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(posedge core_clk) #1;
      insn_valid = 1'b1;
      insn_word = w;
      insn_ext = k;
      @(posedge core_clk) #1;
      insn_valid = 1'b0;
      for (cyc = 1; cyc < 8 && rdy !== 1'b1; cyc++) @(posedge core_clk) #1;
   endtask
   // Shift chain on 0x81, result stored directly
   task automatic t_shift();
      exec(16'he801);
      exec(16'h9506);
      chk({8'h00, sr}, 16'h0009);
      exec(16'h1f00);
      chk({8'h00, sr}, 16'h000c);
      exec(16'h9505);
      chk({8'h00, sr}, 16'h0005);
      exec(16'h9507);
      chk({8'h00, sr}, 16'h000c);
      exec(16'h9502);
      exec(16'h9300, 16'h0200);
      chk(16'(cyc), 16'd2);
      chk(pm.wr_addr, 16'h0200);
      chk({8'h00, pm.wr_data}, 16'h000e);
   endtask
   // Transfer flag and branches, not taken then taken
   task automatic t_branch();
      logic [15:0] p;
      exec(16'hfb01);
      chk({8'h00, sr}, 16'h004c);
      p = pc_q;
      exec(16'hf41e);
      chk(pc_q, p + 16'd1);
      exec(16'h94e8);
      chk({8'h00, sr}, 16'h000c);
      p = pc_q;
      exec(16'hf41e);
      chk(pc_q + 16'(cyc), p + 16'd6);
      exec(16'h9478);
      chk({8'h00, sr}, 16'h008c);
      p = pc_q;
      exec(16'hf01f);
      chk(pc_q, p + 16'd4);
   endtask
   // Post-increment load then store through X
   task automatic t_load();
      exec(16'he1a0);
      exec(16'he0b1);
      exec(16'h911d);
      chk(16'(cyc), 16'd2);
      exec(16'h931c);
      chk(pm.wr_addr, 16'h0111);
      chk({8'h00, pm.wr_data}, 16'h004a);
   endtask
   // I/O bit set and program memory load
   task automatic t_iobit();
      exec(16'h9a2b);
      chk(16'(cyc), 16'd2);
      @(posedge core_clk) #1;
      chk({8'h00, pm.io_mem[5]}, 16'h0089);
      exec(16'h95c8);
      chk(16'(cyc), 16'd3);
      exec(16'h9200, 16'h0300);
      chk({8'h00, pm.wr_data}, 16'h003c);
   endtask
   // Move, port out and in, stack, pre-decrement and displaced forms
   task automatic t_move();
      exec(16'h2c10);
      exec(16'hb816);
      chk(16'(cyc), 16'd1);
      exec(16'hb026);
      chk(16'(cyc), 16'd1);
      exec(16'h922f);
      chk(pm.wr_addr, 16'h00ff);
      chk({8'h00, pm.wr_data}, 16'h003c);
      exec(16'h903f);
      chk(16'(cyc), 16'd2);
      exec(16'h9230, 16'h0400);
      chk({8'h00, pm.wr_data}, 16'h00a5);
      exec(16'h904e);
      exec(16'h824a);
      chk(pm.wr_addr, 16'h0002);
      chk({8'h00, pm.wr_data}, 16'h004a);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Cycle ceiling against hangs
   always @(posedge core_clk) begin
      ticks++;
      if (ticks == 3000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      rst_n = 1'b0;
      {insn_valid, insn_word, insn_ext} = '0;
      repeat (3) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_shift();
      t_branch();
      t_load();
      t_iobit();
      t_move();
      close_out();
   end
endmodule
`default_nettype wire
